//--- logic/uaar_pkg.sv
// Purpose: Shared constants and types for the UART receive path with address match
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Offsets are byte addresses
package uaar_pkg;

	// Register byte offsets
	localparam logic [7:0] UAAR_OFF_CTRL      = 8'h00;
	localparam logic [7:0] UAAR_OFF_STATUS    = 8'h04;
	localparam logic [7:0] UAAR_OFF_MASK      = 8'h08;
	localparam logic [7:0] UAAR_OFF_RXDATA    = 8'h0c;
	localparam logic [7:0] UAAR_OFF_OWN_ADDR  = 8'h10;
	localparam logic [7:0] UAAR_OFF_ADDR_MASK = 8'h14;
	localparam logic [7:0] UAAR_OFF_BAUD      = 8'h18;

	// Control field positions
	localparam int UAAR_CTRL_MODE_LSB = 0;
	localparam int UAAR_CTRL_REN_BIT  = 2;
	localparam int UAAR_CTRL_MPE_BIT  = 3;

	// Status field positions
	localparam int UAAR_ST_RCF_BIT = 0;
	localparam int UAAR_ST_OVR_BIT = 1;
	localparam int UAAR_ST_W       = 2;

	// Reset values
	localparam logic [7:0]  UAAR_RST_OWN_ADDR  = 8'h00;
	localparam logic [7:0]  UAAR_RST_ADDR_MASK = 8'h00;
	localparam logic [15:0] UAAR_RST_BAUD      = 16'h0008;

	// Oversampling: sixteen ticks per bit, sample at the middle
	localparam logic [3:0] UAAR_PH_MID  = 4'h7;
	localparam logic [3:0] UAAR_PH_LAST = 4'hf;
	localparam logic [3:0] UAAR_PH_HALF = 4'h8;
	localparam logic [2:0] UAAR_BIT_LAST = 3'h7;

	// Serial port modes
	localparam logic [1:0] UAAR_MODE0 = 2'h0;
	localparam logic [1:0] UAAR_MODE1 = 2'h1;

	typedef struct packed {
		logic       multiproc_match_enable;
		logic       ren;
		logic [1:0] mode;
	} uaar_ctrl_type;

	typedef enum logic [2:0] {
		UAAR_IDLE  = 3'b000,
		UAAR_START = 3'b001,
		UAAR_DATA  = 3'b010,
		UAAR_NINTH = 3'b011,
		UAAR_STOP  = 3'b100,
		UAAR_SHIFT = 3'b101,
		UAAR_DONE  = 3'b110
	} uaar_state_type;

endpackage

//--- logic/uaar_rx.sv
// Purpose: UART receive path with automatic address recognition, APB registers
// Assumes: Single clock pclk at 20 MHz; rxd comes from a pin
// Notes:   Mode 0 receives on an internal shift clock driven out on shift_clk
//
// Contract
// - Address matching is active in the 9-bit modes 2 and 3 when the match enable bit is set.
// - With matching active an address frame sets the receive flag only on a given or broadcast hit.
// - Ninth bit 1 marks an address and 0 data; software clears match enable to take data.
// - In mode 1 with match enable the stop bit acts as ninth bit and must be valid on a match.
// - In mode 0 the match enable bit has no effect on reception or the receive flag.
// - Given address: mask bit 0 is don't-care, mask bit 1 requires equality with own address.
// - Broadcast address is own address OR mask; its 1 positions must be 1 in the byte.
// - Own address and mask reset to zero so every address matches.
// - In modes 1 to 3 a start bit begins reception only while receive enable is set.
`timescale 1ns/10ps
module uaar_rx
	import uaar_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial line
	input  wire logic        rxd,
	output logic             shift_clk,
	// Interrupt
	output logic             irq
);

	uaar_ctrl_type        ctrl_r;
	logic [7:0]           slave_own_address_r;
	logic [7:0]           slave_address_mask_r;
	logic [15:0]          baud_div_r;
	logic [UAAR_ST_W-1:0] status_r;
	logic [UAAR_ST_W-1:0] irq_mask_r;
	logic [8:0]           rx_buf_r;
	logic [31:0]          prdata_r;
	logic                 pready_r;
	logic                 pslverr_r;
	logic                 irq_r;
	logic                 shift_clk_r;
	logic                 rxd_meta_r;
	logic                 rxd_s_r;
	logic [15:0]          div_cnt_r;
	logic                 tick_r;
	uaar_state_type       state_r;
	logic [3:0]           phase_r;
	logic [2:0]           bit_r;
	logic [7:0]           shreg_r;
	logic                 ninth_r;
	logic                 wr_en;
	logic                 rd_en;
	logic                 addr_ok;
	logic                 given_hit;
	logic                 bcast_hit;
	logic                 qual_bit;
	logic                 accept;
	logic                 set_rcf;
	logic                 set_ovr;
	logic [UAAR_ST_W-1:0] set_vec;
	logic [UAAR_ST_W-1:0] clr_vec;
	logic [7:0]           bcast_addr;

	assign prdata    = prdata_r;
	assign pready    = pready_r;
	assign pslverr   = pslverr_r;
	assign irq       = irq_r;
	assign shift_clk = shift_clk_r;

	// Access completes one cycle into the access phase
	assign wr_en = psel & penable & pready_r & pwrite;
	assign rd_en = psel & penable & ~pready_r & ~pwrite;

	always_comb begin
		addr_ok = (paddr == UAAR_OFF_CTRL) || (paddr == UAAR_OFF_STATUS) ||
			(paddr == UAAR_OFF_MASK) || (paddr == UAAR_OFF_RXDATA) ||
			(paddr == UAAR_OFF_OWN_ADDR) || (paddr == UAAR_OFF_ADDR_MASK) ||
			(paddr == UAAR_OFF_BAUD);
	end

	// APB handshake and read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end else begin
			pready_r  <= psel & penable & ~pready_r;
			pslverr_r <= psel & penable & ~pready_r & ~addr_ok;
			if (rd_en) begin
				if (paddr == UAAR_OFF_CTRL) begin
					prdata_r <= {28'h0000000, ctrl_r};
				end else if (paddr == UAAR_OFF_STATUS) begin
					prdata_r <= {30'h00000000, status_r};
				end else if (paddr == UAAR_OFF_MASK) begin
					prdata_r <= {30'h00000000, irq_mask_r};
				end else if (paddr == UAAR_OFF_RXDATA) begin
					prdata_r <= {23'h000000, rx_buf_r};
				end else if (paddr == UAAR_OFF_OWN_ADDR) begin
					prdata_r <= {24'h000000, slave_own_address_r};
				end else if (paddr == UAAR_OFF_ADDR_MASK) begin
					prdata_r <= {24'h000000, slave_address_mask_r};
				end else if (paddr == UAAR_OFF_BAUD) begin
					prdata_r <= {16'h0000, baud_div_r};
				end else begin
					prdata_r <= 32'h0000_0000;
				end
			end else if (pready_r) begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	// Writable configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r               <= '0;
			slave_own_address_r  <= UAAR_RST_OWN_ADDR;
			slave_address_mask_r <= UAAR_RST_ADDR_MASK;
			baud_div_r           <= UAAR_RST_BAUD;
			irq_mask_r           <= '0;
		end else if (wr_en) begin
			if (paddr == UAAR_OFF_CTRL) begin
				ctrl_r.mode <= pwdata[UAAR_CTRL_MODE_LSB +: 2];
				ctrl_r.ren  <= pwdata[UAAR_CTRL_REN_BIT];
				ctrl_r.multiproc_match_enable <= pwdata[UAAR_CTRL_MPE_BIT];
			end else if (paddr == UAAR_OFF_MASK) begin
				irq_mask_r <= pwdata[UAAR_ST_W-1:0];
			end else if (paddr == UAAR_OFF_OWN_ADDR) begin
				slave_own_address_r <= pwdata[7:0];
			end else if (paddr == UAAR_OFF_ADDR_MASK) begin
				slave_address_mask_r <= pwdata[7:0];
			end else if (paddr == UAAR_OFF_BAUD) begin
				baud_div_r <= pwdata[15:0];
			end
		end
	end

	// Line synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_meta_r <= 1'b1;
			rxd_s_r    <= 1'b1;
		end else begin
			rxd_meta_r <= rxd;
			rxd_s_r    <= rxd_meta_r;
		end
	end

	// Oversampling tick, sixteen per bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= 16'h0000;
			tick_r    <= 1'b0;
		end else if (state_r == UAAR_IDLE || div_cnt_r >= baud_div_r) begin
			div_cnt_r <= 16'h0000;
			tick_r    <= (state_r != UAAR_IDLE);
		end else begin
			div_cnt_r <= div_cnt_r + 16'h0001;
			tick_r    <= 1'b0;
		end
	end

	// Receive sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r     <= UAAR_IDLE;
			phase_r     <= 4'h0;
			bit_r       <= 3'h0;
			shreg_r     <= 8'h00;
			ninth_r     <= 1'b0;
			shift_clk_r <= 1'b1;
		end else begin
			case (state_r)
				UAAR_IDLE: begin
					phase_r     <= 4'h0;
					bit_r       <= 3'h0;
					shift_clk_r <= 1'b1;
					if (ctrl_r.ren) begin
						if (ctrl_r.mode == UAAR_MODE0) begin
							if (!status_r[UAAR_ST_RCF_BIT]) begin
								state_r <= UAAR_SHIFT;
								// No stale ninth bit from an earlier frame
								ninth_r <= 1'b0;
							end
						end else if (!rxd_s_r) begin
							state_r <= UAAR_START;
						end
					end
				end
				UAAR_START: begin
					if (tick_r) begin
						phase_r <= phase_r + 4'h1;
						if (phase_r == UAAR_PH_MID) begin
							phase_r <= 4'h0;
							// False start if line went back high
							state_r <= rxd_s_r ? UAAR_IDLE : UAAR_DATA;
						end
					end
				end
				UAAR_DATA: begin
					if (tick_r) begin
						phase_r <= phase_r + 4'h1;
						if (phase_r == UAAR_PH_LAST) begin
							shreg_r <= {rxd_s_r, shreg_r[7:1]};
							bit_r   <= bit_r + 3'h1;
							if (bit_r == UAAR_BIT_LAST) begin
								state_r <= (ctrl_r.mode == UAAR_MODE1) ? UAAR_STOP : UAAR_NINTH;
							end
						end
					end
				end
				UAAR_NINTH: begin
					if (tick_r) begin
						phase_r <= phase_r + 4'h1;
						if (phase_r == UAAR_PH_LAST) begin
							ninth_r <= rxd_s_r;
							state_r <= UAAR_STOP;
						end
					end
				end
				UAAR_STOP: begin
					if (tick_r) begin
						phase_r <= phase_r + 4'h1;
						if (phase_r == UAAR_PH_LAST) begin
							// Mode 1 keeps the stop bit in the ninth position
							if (ctrl_r.mode == UAAR_MODE1) begin
								ninth_r <= rxd_s_r;
							end
							state_r <= UAAR_DONE;
						end
					end
				end
				UAAR_SHIFT: begin
					if (tick_r) begin
						phase_r     <= phase_r + 4'h1;
						shift_clk_r <= (phase_r >= UAAR_PH_HALF - 4'h1) &&
							(phase_r != UAAR_PH_LAST);
						if (phase_r == UAAR_PH_LAST) begin
							shreg_r <= {rxd_s_r, shreg_r[7:1]};
							bit_r   <= bit_r + 3'h1;
							if (bit_r == UAAR_BIT_LAST) begin
								state_r <= UAAR_DONE;
							end
						end
					end
				end
				UAAR_DONE: begin
					state_r <= UAAR_IDLE;
				end
				default: begin
					state_r <= UAAR_IDLE;
				end
			endcase
		end
	end

	// Address recognition on the eight data bits only
	always_comb begin
		bcast_addr = slave_own_address_r | slave_address_mask_r;
		given_hit  = ((shreg_r ^ slave_own_address_r) & slave_address_mask_r) == 8'h00;
		bcast_hit  = (shreg_r & bcast_addr) == bcast_addr;
		qual_bit   = ninth_r;
		if (ctrl_r.mode == UAAR_MODE0) begin
			accept = 1'b1;
		end else if (ctrl_r.multiproc_match_enable) begin
			accept = qual_bit & (given_hit | bcast_hit);
		end else begin
			accept = 1'b1;
		end
		set_rcf = (state_r == UAAR_DONE) && accept && !status_r[UAAR_ST_RCF_BIT];
		set_ovr = (state_r == UAAR_DONE) && accept && status_r[UAAR_ST_RCF_BIT];
		set_vec = '0;
		set_vec[UAAR_ST_RCF_BIT] = set_rcf;
		set_vec[UAAR_ST_OVR_BIT] = set_ovr;
		clr_vec = (wr_en && paddr == UAAR_OFF_STATUS) ? pwdata[UAAR_ST_W-1:0] : '0;
	end

	// Receive buffer loads only on an accepted frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_buf_r <= 9'h000;
		end else if (set_rcf) begin
			rx_buf_r <= {ninth_r, shreg_r};
		end
	end

	// Sticky status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= '0;
			irq_r    <= 1'b0;
		end else begin
			status_r <= (status_r & ~clr_vec) | set_vec;
			irq_r    <= |(((status_r & ~clr_vec) | set_vec) & irq_mask_r);
		end
	end

endmodule // uaar_rx

//--- verification/uaar_rx_monitor.sv
// Purpose: Port-level checks of the APB slave and interrupt of uaar_rx
// Assumes: Single pclk domain, presetn async active low
// Notes:   Sees only top-level ports
`timescale 1ns/10ps
module uaar_rx_monitor
	import uaar_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Interrupt
	input wire logic        irq
);
	logic seen_w;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Address registers written since reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			seen_w <= 1'b0;
		else if (pready && pwrite &&
			(paddr == UAAR_OFF_OWN_ADDR || paddr == UAAR_OFF_ADDR_MASK))
			seen_w <= 1'b1;
	end

	property p_one_wait;
		psel && $rose(penable) |-> !pready ##1 pready;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");

	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");

	property p_rd_zero;
		!pready |-> prdata == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("prdata not zero when idle");

	property p_err_map;
		pready |-> pslverr == (paddr > UAAR_OFF_BAUD || paddr[1:0] != 2'h0);
	endproperty
	a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");

	property p_ready_req;
		pready |-> psel && penable;
	endproperty
	a_ready_req: assert property (p_ready_req) else $error("pready without access");

	property p_err_data;
		pslverr |-> prdata == 32'h0;
	endproperty
	a_err_data: assert property (p_err_data) else $error("refused read data not zero");

	property p_rst_addr;
		pready && !pwrite && !seen_w &&
			(paddr == UAAR_OFF_OWN_ADDR || paddr == UAAR_OFF_ADDR_MASK)
			|-> prdata == 32'h0;
	endproperty
	a_rst_addr: assert property (p_rst_addr) else $error("address reg not zero");

	property p_irq_off;
		pready && pwrite && paddr == UAAR_OFF_MASK && pwdata[1:0] == 2'h0 |=> ##1 !irq [*3];
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq high with mask clear");
endmodule // uaar_rx_monitor

//--- verification/uaar_uart_master.sv
// Purpose: Master UART on the shared line, sends address and data frames
// Assumes: Line idles high; bit time in pclk cycles
// Notes:   Start, LSB first data, optional ninth bit, stop
`timescale 1ns/10ps
module uaar_uart_master (
	// Clock and serial line
	input  wire logic pclk,
	output logic      rxd
);
	int bit_cyc = 16;

	initial rxd = 1'b1;

	// Ninth bit 1 for address, 0 for data
	task automatic send(input logic [8:0] d, input int nb, input logic stp);
		for (int i = -1; i <= nb; i++) begin
			rxd <= (i < 0) ? 1'b0 : (i == nb) ? stp : d[i];
			repeat (bit_cyc) @(posedge pclk);
		end
		rxd <= 1'b1;
	endtask
endmodule // uaar_uart_master

//--- verification/uaar_rx_bench.sv
// Purpose: Self-checking bench for uaar_rx address recognition
// Assumes: Baud divider 0, so one bit is 16 pclk cycles
// Notes:   Reads note expected data in a queue, a watcher compares
`timescale 1ns/10ps
module uaar_rx_bench;
	import uaar_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, msk = 1;
	logic [7:0]  paddr = '0, own, mk, b;
	logic [31:0] pwdata = '0, prdata;
	logic        pready, pslverr, rxd, shift_clk, irq;
	logic [31:0] exp_q[$];
	logic [7:0]  tb[5] = '{8'hf0, 8'hf4, 8'hf2, 8'hff, 8'h70};
	int          n_errors = 0, checks = 0, cyc = 0, n_fall = 0;
	logic        sclk_q;

	always #25 pclk = ~pclk;

	uaar_rx dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .shift_clk(shift_clk), .irq(irq));
	uaar_uart_master far (.pclk(pclk), .rxd(rxd));

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic ctl(input logic mpe, input logic ren, input logic [1:0] md);
		apb(1'b1, UAAR_OFF_CTRL, {28'h0, mpe, ren, md});
	endtask

	task automatic setaddr(input logic [7:0] o, input logic [7:0] m);
		own = o;
		mk = m;
		apb(1'b1, UAAR_OFF_OWN_ADDR, {24'h0, o});
		apb(1'b1, UAAR_OFF_ADDR_MASK, {24'h0, m});
	endtask

	// Given hit or broadcast hit on the eight data bits
	function automatic logic hit(input logic [7:0] x);
		return (((x ^ own) & mk) == 8'h0) || ((x & (own | mk)) == (own | mk));
	endfunction

	task automatic rx(input logic [8:0] d, input int nb, input logic stp, input logic h);
		far.send(d, nb, stp);
		repeat (40) @(posedge pclk);
		checks++;
		if (irq !== (h & msk)) begin
			n_errors++;
			$display("[FAIL] %0t irq %b", $time, irq);
		end
		rd(UAAR_OFF_STATUS, {31'h0, h});
		if (h)
			rd(UAAR_OFF_RXDATA, {23'h0, d});
		apb(1'b1, UAAR_OFF_STATUS, 32'h3);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			checks++;
			if (prdata !== exp_q[0]) begin
				n_errors++;
				$display("[FAIL] %0t read %h expected %h", $time, prdata, exp_q[0]);
			end
			void'(exp_q.pop_front());
		end
	end

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			final_report;
		end
	end

	// Falling edges of the mode 0 shift clock
	always @(posedge pclk) begin
		sclk_q <= shift_clk;
		if (sclk_q === 1'b1 && shift_clk === 1'b0)
			n_fall++;
	end

	task final_report;
		$display("Checks %0d, errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		void'($urandom(32'h32cd));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(UAAR_OFF_OWN_ADDR, 32'h0);
		rd(UAAR_OFF_ADDR_MASK, 32'h0);
		rd(8'h40, 32'h0);
		apb(1'b1, UAAR_OFF_BAUD, 32'h0);
		apb(1'b1, UAAR_OFF_MASK, 32'h1);
		ctl(1'b1, 1'b1, 2'h2);
		rx(9'h123, 9, 1'b1, 1'b1);
		setaddr(8'hf1, 8'hfa);
		ctl(1'b1, 1'b1, 2'h3);
		foreach (tb[i]) rx({1'b1, tb[i]}, 9, 1'b1, hit(tb[i]));
		rx(9'h0f0, 9, 1'b1, 1'b0);
		ctl(1'b1, 1'b1, 2'h1);
		rx(9'h1f0, 8, 1'b1, 1'b1);
		rx(9'h0f0, 8, 1'b0, 1'b0);
		ctl(1'b0, 1'b1, 2'h2);
		rx(9'h055, 9, 1'b1, 1'b1);
		ctl(1'b0, 1'b0, 2'h2);
		rx(9'h155, 9, 1'b1, 1'b0);
		ctl(1'b1, 1'b1, 2'h3);
		for (int i = 0; i < 6; i++) begin
			setaddr(8'($urandom), 8'($urandom));
			b = i[0] ? 8'($urandom) : own ^ (~mk & 8'($urandom));
			rx({1'b1, b}, 9, 1'b1, hit(b));
		end
		apb(1'b1, UAAR_OFF_MASK, 32'h0);
		msk = 1'b0;
		rx(9'h1ff, 9, 1'b1, 1'b1);
		ctl(1'b1, 1'b1, 2'h0);
		repeat (200) @(posedge pclk);
		ctl(1'b1, 1'b0, 2'h0);
		rd(UAAR_OFF_STATUS, 32'h1);
		rd(UAAR_OFF_RXDATA, 32'h0ff);
		checks++;
		// One fall opens bit 0, then one per sampled bit; idle high after
		if (n_fall != 9 || shift_clk !== 1'b1) begin
			n_errors++;
			$display("[FAIL] %0t shift clock falls %0d", $time, n_fall);
		end
		final_report;
	end
endmodule // uaar_rx_bench

bind uaar_rx uaar_rx_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq));
